/* File: hw/mtc_pkg.sv */
// Package for the modulo timer core: register offsets, field positions,
// reset values and the register bus request carrier.
// Assumes a byte-wide register port on a single 20 MHz bus clock.

package mtc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte port, one register per address)
  // ----------------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL    = 3'h0;
  localparam logic [2:0] OFS_CNT_HI  = 3'h1;
  localparam logic [2:0] OFS_CNT_LO  = 3'h2;
  localparam logic [2:0] OFS_LIM_HI  = 3'h3;
  localparam logic [2:0] OFS_LIM_LO  = 3'h4;
  localparam logic [2:0] OFS_CHAN    = 3'h5;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_OVF_FLAG = 7;
  localparam int CTRL_OVF_IE   = 6;
  localparam int CTRL_HALT     = 5;
  localparam int CTRL_CLR      = 4;
  localparam int CTRL_DIV_LSB  = 0;
  localparam int CHAN_FLAG_LSB = 0;
  localparam int CHAN_IE_LSB   = 4;
  localparam int NUM_CHAN      = 2;

  // ----------------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------------
  localparam logic        RST_HALT  = 1'b1;
  localparam logic        RST_IE    = 1'b0;
  localparam logic [2:0]  RST_DIV   = 3'h0;
  localparam logic [15:0] RST_LIMIT = 16'hFFFF;
  localparam logic [15:0] RST_CNT   = 16'h0000;
  localparam logic [5:0]  RST_PRESC = 6'h00;
  localparam logic [2:0]  DIV_EXT   = 3'h7;

  // Register bus request, one cycle wide strobes
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mtc_bus_req_t;

endpackage : mtc_pkg

/* File: hw/mtc_timer_core.sv */
// Modulo timer core: prescaler, 16-bit modulo counter, overflow flag,
// count readout latch, channel event flags and interrupt request levels.
// Assumes wait, stop, break and channel events come from logic on mclk;
// only the external count clock pin is asynchronous.

`timescale 1ns/10ps

// Summary of operation
// - Count advances on bus clock when tick due
// - Overflow flag set edge after rollover
// - Count equal limit sets flag, restarts zero
// - Flag cleared by read-then-write-zero only
// - Overflow request needs flag and enable
// - Channel events set flags, enable gates request
// - Halt bit freezes count; reset sets it
// - Halt inhibits captures on capture channels
// - Clear bit zeroes counter, readout, prescaler
// - Halt with clear holds count at zero
// - Divider select picks bus divide or pin
// - Pin forced input while external clock selected
// - High read latches low byte until read
// - Limit high write blocks flag until low
// - Limit resets to all ones
// - Wait keeps counting, refuses access, wakes
// - Stop freezes everything, keeps state
// - Break stops counter and blocks captures
// - Break flag clears only with clear enable
module mtc_timer_core
  import mtc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire mtc_bus_req_t         bus_req,
  output logic [7:0]                rdata,
  input  wire logic                 ext_clock_input,
  input  wire logic                 wait_mode,
  input  wire logic                 stop_mode,
  input  wire logic                 break_active,
  input  wire logic                 break_flag_clear_enable,
  input  wire logic [NUM_CHAN-1:0]  chan_capture_mode,
  input  wire logic [NUM_CHAN-1:0]  chan_capture_evt,
  input  wire logic [NUM_CHAN-1:0]  chan_compare_evt,
  output logic [15:0]               count_value,
  output logic                      overflow_irq,
  output logic [NUM_CHAN-1:0]       chan_irq,
  output logic                      wake_request,
  output logic                      ext_pin_force_input,
  output logic [NUM_CHAN-1:0]       capture_allow
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                acc_ok;
  logic                flag_clr_ok;
  logic                wr_ctrl;
  logic                rd_ctrl;
  logic                wr_chan;
  logic                rd_chan;
  logic                clr_write;
  logic                overflow_flag;
  logic                ovf_armed;
  logic                overflow_irq_enable;
  logic                count_halt;
  logic [2:0]          clock_divider_select;
  logic [15:0]         limit;
  logic                lim_hold;
  logic [7:0]          lo_buf;
  logic                latched;
  logic [5:0]          presc;
  logic [5:0]          presc_mask;
  logic                src_tick;
  logic                run;
  logic                cnt_tick;
  logic                ovf_evt;
  logic                ext_s1;
  logic                ext_s2;
  logic                ext_s3;
  logic [NUM_CHAN-1:0] channel_event_flag;
  logic [NUM_CHAN-1:0] chan_armed;
  logic [NUM_CHAN-1:0] channel_irq_enable;

  // ----------------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------------
  // CPU access refused in wait and stop
  assign acc_ok      = !wait_mode && !stop_mode;
  // Status flags protected during break unless enabled
  assign flag_clr_ok = !break_active || break_flag_clear_enable;
  assign wr_ctrl     = bus_req.wr && acc_ok && (bus_req.addr == OFS_CTRL);
  assign rd_ctrl     = bus_req.rd && acc_ok && (bus_req.addr == OFS_CTRL);
  assign wr_chan     = bus_req.wr && acc_ok && (bus_req.addr == OFS_CHAN);
  assign rd_chan     = bus_req.rd && acc_ok && (bus_req.addr == OFS_CHAN);
  assign clr_write   = wr_ctrl && bus_req.wdata[CTRL_CLR];

  // ----------------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------------
  // Two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge mclk) begin
    if (srst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_clock_input;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Divide by 2^n: tick when the low n prescaler bits are all ones
  assign presc_mask = 6'((7'h01 << clock_divider_select) - 7'h01);
  assign src_tick   = (clock_divider_select == DIV_EXT) ? (ext_s2 && !ext_s3)
                                                        : ((presc & presc_mask) == presc_mask);
  // Counting stops on halt, stop mode or break; wait mode keeps it going
  assign run        = !count_halt && !stop_mode && !break_active;
  assign cnt_tick   = run && src_tick;

  // Prescaler, free running while the counter runs
  always_ff @(posedge mclk) begin
    if (srst) begin
      presc <= RST_PRESC;
    end else if (clr_write) begin
      presc <= RST_PRESC;
    end else if (run) begin
      presc <= presc + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Bus-clock edge stands for the internal falling edge of the bus clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      count_value <= RST_CNT;
    end else if (clr_write) begin
      count_value <= RST_CNT;
    end else if (cnt_tick) begin
      if (count_value == limit) begin
        count_value <= RST_CNT;
      end else begin
        count_value <= count_value + 16'h0001;
      end
    end
  end

  // Rollover event, flag follows one edge later
  always_ff @(posedge mclk) begin
    if (srst) begin
      ovf_evt <= 1'b0;
    end else begin
      ovf_evt <= cnt_tick && (count_value == limit) && !clr_write;
    end
  end

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  // Halt resets high so the counter waits for software
  always_ff @(posedge mclk) begin
    if (srst) begin
      overflow_irq_enable  <= RST_IE;
      count_halt           <= RST_HALT;
      clock_divider_select <= RST_DIV;
    end else if (wr_ctrl) begin
      overflow_irq_enable  <= bus_req.wdata[CTRL_OVF_IE];
      count_halt           <= bus_req.wdata[CTRL_HALT];
      clock_divider_select <= bus_req.wdata[CTRL_DIV_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------------
  // Overflow flag with two-step clear
  // ----------------------------------------------------------------------
  // Set wins over clear; a new overflow disarms the pending clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      overflow_flag <= 1'b0;
      ovf_armed     <= 1'b0;
    end else if (ovf_evt && !lim_hold) begin
      overflow_flag <= 1'b1;
      ovf_armed     <= 1'b0;
    end else if (wr_ctrl && flag_clr_ok) begin
      if (ovf_armed && !bus_req.wdata[CTRL_OVF_FLAG]) begin
        overflow_flag <= 1'b0;
      end
      ovf_armed <= 1'b0;
    end else if (rd_ctrl && flag_clr_ok && overflow_flag) begin
      ovf_armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------------
  // High byte write holds off the flag until the pair is complete
  always_ff @(posedge mclk) begin
    if (srst) begin
      limit    <= RST_LIMIT;
      lim_hold <= 1'b0;
    end else if (bus_req.wr && acc_ok && (bus_req.addr == OFS_LIM_HI)) begin
      limit[15:8] <= bus_req.wdata;
      lim_hold    <= 1'b1;
    end else if (bus_req.wr && acc_ok && (bus_req.addr == OFS_LIM_LO)) begin
      limit[7:0]  <= bus_req.wdata;
      lim_hold    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Count readout latch
  // ----------------------------------------------------------------------
  // Latch stays frozen across break until the low byte is read
  always_ff @(posedge mclk) begin
    if (srst) begin
      lo_buf  <= 8'h00;
      latched <= 1'b0;
    end else if (clr_write) begin
      lo_buf  <= 8'h00;
      latched <= 1'b0;
    end else if (bus_req.rd && acc_ok && (bus_req.addr == OFS_CNT_HI) && !latched) begin
      lo_buf  <= count_value[7:0];
      latched <= 1'b1;
    end else if (bus_req.rd && acc_ok && (bus_req.addr == OFS_CNT_LO)) begin
      latched <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Channel event flags
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      logic ch_evt;
      // Captures only count while allowed; compares are gated by stop mode alone
      assign ch_evt = !stop_mode && (chan_capture_mode[gi]
                      ? (chan_capture_evt[gi] && capture_allow[gi])
                      : chan_compare_evt[gi]);

      // Capture gate: closed by halt on capture channels and by break
      always_ff @(posedge mclk) begin
        if (srst) begin
          capture_allow[gi] <= 1'b0;
        end else begin
          capture_allow[gi] <= !break_active
                               && !(count_halt && chan_capture_mode[gi]);
        end
      end

      // Same two-step clear as the overflow flag
      always_ff @(posedge mclk) begin
        if (srst) begin
          channel_event_flag[gi] <= 1'b0;
          chan_armed[gi]         <= 1'b0;
        end else if (ch_evt) begin
          channel_event_flag[gi] <= 1'b1;
          chan_armed[gi]         <= 1'b0;
        end else if (wr_chan && flag_clr_ok) begin
          if (chan_armed[gi] && !bus_req.wdata[CHAN_FLAG_LSB + gi]) begin
            channel_event_flag[gi] <= 1'b0;
          end
          chan_armed[gi] <= 1'b0;
        end else if (rd_chan && flag_clr_ok && channel_event_flag[gi]) begin
          chan_armed[gi] <= 1'b1;
        end
      end

      // Interrupt enable per channel
      always_ff @(posedge mclk) begin
        if (srst) begin
          channel_irq_enable[gi] <= RST_IE;
        end else if (wr_chan) begin
          channel_irq_enable[gi] <= bus_req.wdata[CHAN_IE_LSB + gi];
        end
      end

      // Level request while flag and enable both set
      always_ff @(posedge mclk) begin
        if (srst) begin
          chan_irq[gi] <= 1'b0;
        end else begin
          chan_irq[gi] <= channel_event_flag[gi] && channel_irq_enable[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Outputs: requests, wake, pin direction override
  // ----------------------------------------------------------------------
  // One cycle behind the flag, so every output is a flop
  always_ff @(posedge mclk) begin
    if (srst) begin
      overflow_irq        <= 1'b0;
      wake_request        <= 1'b0;
      ext_pin_force_input <= 1'b0;
    end else begin
      overflow_irq        <= overflow_flag && overflow_irq_enable;
      wake_request        <= wait_mode && ((overflow_flag && overflow_irq_enable)
                             || |(channel_event_flag & channel_irq_enable));
      ext_pin_force_input <= (clock_divider_select == DIV_EXT);
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Unmapped, refused and idle cycles read zero; clear bit reads zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (bus_req.rd && acc_ok) begin
      case (bus_req.addr)
        OFS_CTRL:   rdata <= {overflow_flag, overflow_irq_enable, count_halt, 2'b00,
                              clock_divider_select};
        OFS_CNT_HI: rdata <= count_value[15:8];
        OFS_CNT_LO: rdata <= latched ? lo_buf : count_value[7:0];
        OFS_LIM_HI: rdata <= limit[15:8];
        OFS_LIM_LO: rdata <= limit[7:0];
        OFS_CHAN:   rdata <= {2'b00, channel_irq_enable, 2'b00, channel_event_flag};
        default:    rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  halt_freeze_a: assert property ((count_halt && !clr_write) |=> $stable(count_value))
    else $error("count moved while halted");
  ovf_flag_a: assert property ((ovf_evt && !lim_hold) |=> overflow_flag)
    else $error("overflow flag not set after rollover");
  wrap_zero_a: assert property ((cnt_tick && !clr_write && count_value == limit)
                                |=> (count_value == 16'h0000) ##1 overflow_flag || lim_hold)
    else $error("counter did not wrap at limit");
  one_keeps_a: assert property ((wr_ctrl && bus_req.wdata[CTRL_OVF_FLAG] && overflow_flag)
                                |=> overflow_flag)
    else $error("writing one changed the flag");
  ovf_irq_a: assert property ((overflow_flag && overflow_irq_enable) |=> overflow_irq)
    else $error("overflow request missing");
  irq_drop_a: assert property (!overflow_flag |=> !overflow_irq)
    else $error("overflow request without flag");
  clear_count_a: assert property (clr_write |=> (count_value == 16'h0000) && (presc == 6'h00)
                                  && !latched)
    else $error("clear bit did not zero counter");
  latch_hold_a: assert property ((latched && !clr_write
                                  && !(bus_req.rd && acc_ok && bus_req.addr == OFS_CNT_LO))
                                 |=> latched && $stable(lo_buf))
    else $error("latched low byte changed");
  limit_hold_a: assert property (lim_hold |=> !$rose(overflow_flag))
    else $error("flag set during limit update");
  wait_refuse_a: assert property ((wait_mode && bus_req.rd) |=> rdata == 8'h00)
    else $error("register read during wait");
  break_block_a: assert property (break_active |=> capture_allow == '0)
    else $error("capture allowed during break");
  break_keep_a: assert property ((break_active && !break_flag_clear_enable && overflow_flag)
                                 |=> overflow_flag)
    else $error("flag cleared in protected break");

endmodule : mtc_timer_core

/* File: verif/mtc_ext_clk_src.sv */
// Far-side model: external count clock pin for the timer core bench.
// Assumes the bench asks for bursts; the pin rests low between them.
`timescale 1ns/10ps

module mtc_ext_clk_src (
  output logic pin
);
  // -----------------------------------------------------------------
  // Pulse source
  // -----------------------------------------------------------------
  // 150 ns half period: 3.33 MHz, below 4 MHz and below bus rate / 2
  localparam time HALF = 150ns;

  initial pin = 1'b0;

  // Whole pulses only, so the core never sees a clipped edge
  task automatic burst(input int n);
    repeat (n) begin
      #HALF pin = 1'b1;
      #HALF pin = 1'b0;
    end
  endtask : burst
endmodule : mtc_ext_clk_src

/* File: verif/tb_top.sv */
// Testbench for the modulo timer core: register tasks and scenarios.
// Assumes a 20 MHz mclk and the register map of the core package.
`timescale 1ns/10ps

module tb_top;
  import mtc_pkg::*;
  logic                mclk;
  logic                srst;
  mtc_bus_req_t        req;
  logic [7:0]          rdata;
  logic                ext_pin;
  logic                wait_mode;
  logic                stop_mode;
  logic                brk;
  logic                bfce;
  logic [NUM_CHAN-1:0] cap_mode;
  logic [NUM_CHAN-1:0] cap_evt;
  logic [NUM_CHAN-1:0] cmp_evt;
  logic [15:0]         count_value;
  logic                overflow_irq;
  logic [NUM_CHAN-1:0] chan_irq;
  logic                wake_request;
  logic                force_in;
  logic [NUM_CHAN-1:0] capture_allow;
  logic [7:0]          rv;
  logic [15:0]         snap;
  logic [15:0]         s1;
  logic [15:0]         a;
  logic [15:0]         e;
  int                  bad_count;
  int                  tests_run;

  mtc_timer_core mtc_timer_core_i (
    .mclk                    (mclk),
    .srst                    (srst),
    .bus_req                 (req),
    .rdata                   (rdata),
    .ext_clock_input         (ext_pin),
    .wait_mode               (wait_mode),
    .stop_mode               (stop_mode),
    .break_active            (brk),
    .break_flag_clear_enable (bfce),
    .chan_capture_mode       (cap_mode),
    .chan_capture_evt        (cap_evt),
    .chan_compare_evt        (cmp_evt),
    .count_value             (count_value),
    .overflow_irq            (overflow_irq),
    .chan_irq                (chan_irq),
    .wake_request            (wake_request),
    .ext_pin_force_input     (force_in),
    .capture_allow           (capture_allow)
  );

  mtc_ext_clk_src mtc_ext_clk_src_i (
    .pin (ext_pin)
  );

  // -----------------------------------------------------------------
  // Clock and helpers
  // -----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic test_done();
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  // Release then idle one edge, so no strobe is driven twice a step
  task automatic bus_wr(input logic [2:0] ad, input logic [7:0] d);
    req <= '{ad, d, 1'b1, 1'b0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask : bus_wr

  // Snapshot is the count the core sees at the taken edge
  task automatic bus_rd(input logic [2:0] ad);
    req <= '{ad, 8'h00, 1'b0, 1'b1};
    #1 snap = count_value;
    @(posedge mclk);
    req <= '0;
    #1 rv = rdata;
    @(posedge mclk);
  endtask : bus_rd

  task automatic rdc(input logic [2:0] ad, input logic [7:0] x);
    bus_rd(ad);
    chk({8'h00, rv}, {8'h00, x});
  endtask : rdc

  // Event pulses last one clock and change by non-blocking assignment, like the bus
  task automatic pulse(input logic [NUM_CHAN-1:0] c, input logic [NUM_CHAN-1:0] m);
    cap_evt <= c;
    cmp_evt <= m;
    @(posedge mclk);
    cap_evt <= '0;
    cmp_evt <= '0;
    wt(3);
  endtask : pulse

  // -----------------------------------------------------------------
  // Watchdog: whole run needs about 2200 cycles
  // -----------------------------------------------------------------
  initial begin
    wt(20000);
    bad_count++;
    test_done();
  end

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  initial begin
    bad_count = 0;
    tests_run = 0;
    {srst, req, wait_mode, stop_mode, brk, bfce} = {1'b1, 13'h0, 4'h0};
    {cap_mode, cap_evt, cmp_evt} = {2'b01, 4'h0};
    wt(6);
    srst <= 1'b0;
    @(posedge mclk);
    rdc(OFS_CTRL, 8'h20);
    rdc(OFS_LIM_HI, 8'hff);
    rdc(OFS_LIM_LO, 8'hff);
    rdc(3'h6, 8'h00);
    wt(20);
    chk(count_value, 16'h0000);
    // Each bus divider over 256 run cycles, two counts of slack
    for (int n = 0; n < 7; n++) begin
      bus_wr(OFS_CTRL, 8'h30 | 8'(n));
      chk(count_value, 16'h0000);
      bus_wr(OFS_CTRL, 8'(n));
      wt(254);
      bus_wr(OFS_CTRL, 8'h20 | 8'(n));
      e = 16'd256 >> n;
      chk({15'h0, count_value + 2 >= e && count_value <= e + 2}, 1);
    end
    bus_wr(OFS_CTRL, 8'h37);
    bus_wr(OFS_CTRL, 8'h07);
    chk({15'h0, force_in}, 1);
    mtc_ext_clk_src_i.burst(10);
    wt(6);
    chk(count_value, 16'd10);
    bus_wr(OFS_CTRL, 8'h20);
    wt(1);
    chk({15'h0, force_in}, 0);
    // Readout latch while counting every cycle
    bus_wr(OFS_CTRL, 8'h00);
    bus_rd(OFS_CNT_HI);
    s1 = snap;
    chk({8'h00, rv}, {8'h00, s1[15:8]});
    wt(5);
    bus_rd(OFS_CNT_HI);
    rdc(OFS_CNT_LO, s1[7:0]);
    bus_rd(OFS_CNT_LO);
    chk({8'h00, rv}, {8'h00, snap[7:0]});
    bus_wr(OFS_CTRL, 8'h10);
    rdc(OFS_CTRL, 8'h00);
    rdc(OFS_LIM_HI, 8'hff);
    // Modulo 5 with overflow requests enabled
    bus_wr(OFS_CTRL, 8'h30);
    bus_wr(OFS_LIM_HI, 8'h00);
    bus_wr(OFS_LIM_LO, 8'h05);
    bus_wr(OFS_CTRL, 8'h40);
    a = '0;
    repeat (40) begin
      @(posedge mclk);
      if (count_value > a) a = count_value;
    end
    chk(a, 16'h0005);
    chk({15'h0, overflow_irq}, 1);
    bus_wr(OFS_CTRL, 8'h60);
    rdc(OFS_CTRL, 8'he0);
    bus_wr(OFS_CTRL, 8'he0);
    rdc(OFS_CTRL, 8'he0);
    bus_wr(OFS_CTRL, 8'h60);
    rdc(OFS_CTRL, 8'h60);
    wt(2);
    chk({15'h0, overflow_irq}, 0);
    // A new overflow between read and write keeps the flag
    bus_wr(OFS_CTRL, 8'h00);
    wt(10);
    bus_rd(OFS_CTRL);
    wt(10);
    bus_wr(OFS_CTRL, 8'h20);
    rdc(OFS_CTRL, 8'ha0);
    bus_wr(OFS_CTRL, 8'h30);
    bus_wr(OFS_LIM_HI, 8'h00);
    bus_wr(OFS_CTRL, 8'h40);
    wt(30);
    chk({15'h0, overflow_irq}, 0);
    bus_wr(OFS_LIM_LO, 8'h05);
    for (int i = 0; i < 20 && overflow_irq !== 1'b1; i++) @(posedge mclk);
    chk({15'h0, overflow_irq}, 1);
    // Wait refuses access but keeps counting
    wait_mode <= 1'b1;
    wt(2);
    chk({15'h0, wake_request}, 1);
    rdc(OFS_CTRL, 8'h00);
    a = count_value;
    bus_wr(OFS_LIM_HI, 8'h12);
    chk({15'h0, count_value !== a}, 1);
    wait_mode <= 1'b0;
    @(posedge mclk);
    rdc(OFS_LIM_HI, 8'h00);
    stop_mode <= 1'b1;
    wt(2);
    a = count_value;
    wt(20);
    chk(count_value, a);
    stop_mode <= 1'b0;
    wt(3);
    chk({15'h0, count_value !== a}, 1);
    rdc(OFS_LIM_LO, 8'h05);
    // Break freezes count; flags clear only with clear enable
    brk <= 1'b1;
    wt(2);
    a = count_value;
    wt(10);
    chk(count_value, a);
    chk({14'h0, capture_allow}, 0);
    // Low byte read before break ends, so the latch is released
    bus_rd(OFS_CNT_HI);
    rdc(OFS_CNT_LO, snap[7:0]);
    rdc(OFS_CTRL, 8'hc0);
    bus_wr(OFS_CTRL, 8'h40);
    rdc(OFS_CTRL, 8'hc0);
    bfce <= 1'b1;
    rdc(OFS_CTRL, 8'hc0);
    bus_wr(OFS_CTRL, 8'h40);
    rdc(OFS_CTRL, 8'h40);
    {brk, bfce} <= 2'b00;
    // Channels: halt closes the capture channel only
    bus_wr(OFS_CTRL, 8'h20);
    wt(1);
    chk({14'h0, capture_allow}, 2);
    pulse(2'b01, 2'b00);
    rdc(OFS_CHAN, 8'h00);
    bus_wr(OFS_CHAN, 8'h30);
    pulse(2'b00, 2'b10);
    chk({14'h0, chan_irq}, 2);
    rdc(OFS_CHAN, 8'h32);
    bus_wr(OFS_CHAN, 8'h30);
    wt(2);
    chk({14'h0, chan_irq}, 0);
    bus_wr(OFS_CTRL, 8'h00);
    wt(2);
    pulse(2'b01, 2'b00);
    rdc(OFS_CHAN, 8'h31);
    test_done();
  end
endmodule : tb_top
